/* File: design/pcbc_top.sv */
// Design: 10-bit PWM compare unit with block commutation and multi-phase PWM
// Summary of operation
// - Ten-bit timer counts from zero to period value, then restarts at zero
// - Timer equal to match value toggles the single PWM pin
// - Timer wrapping to zero toggles the single PWM pin again
// - In multi-phase and burst modes, modulated signal may drive paired outputs
// - Inversion bit inverts modulated signal on paired outputs in those modes
// - Outputs driven by Hall inputs, by external timer zero or software
// - Each external timer zero advances multi-phase outputs one table step
// - Multi-phase variants drive four, five or six output signals
// - Hall inputs are sampled once every clock cycle in block mode
// - Hall change updates six outputs; slow-down and idle rows fixed
// - Rotate left, shift select low, maps Hall codes to the listed pairs
// - Rotate left, shift select high, maps Hall codes to the listed pairs
// - Rotate right maps Hall codes to its listed output pairs
// - In rotate-left and rotate-right modes, all-zero or all-one Hall code sets error flag and forces idle
// - Error flag with emergency enable raises the emergency request
// - With follower check on, a wrong successor code forces idle
// - Every entry into idle sets the commutation error flag
// - Idle is held until software clears the error flag
`default_nettype none
module pcbc_top (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Configuration
  input  wire pcbc_pkg::pcbc_cfg_s cfg,
  input  wire pcbc_pkg::pcbc_tmr_s tmr,
  input  wire logic               count_tick,
  // Triggers
  input  wire logic [2:0]         hall_inputs,
  input  wire logic               ct1_zero,
  input  wire logic               sw_step,
  input  wire logic               error_clear,
  // Outputs
  output logic                    single_pwm_pin,
  output logic [2:0]              primary_out,
  output logic [2:0]              paired_out,
  output logic                    commutation_error_flag,
  output logic                    emergency_irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [9:0] count;
    logic       pwm;
    logic [2:0] hall_s;
    logic [2:0] hall_last;
    logic       last_valid;
    logic       idle;
    logic       err;
    logic       irq;
    logic [2:0] step;
    logic [5:0] pattern;
    logic [2:0] prim;
    logic [2:0] pair;
  } pcbc_st_s;

  pcbc_st_s st;
  pcbc_st_s next_st;

  // ****************************************
  // Decoders
  // ****************************************
  // Active pattern {Q2,Q1,Q0,P2,P1,P0} for a Hall code {in0,in1,in2}
  function automatic logic [5:0] pcbc_decode(
    input pcbc_pkg::pcbc_bc_e m,
    input logic               tsel,
    input logic [2:0]         c
  );
    logic [5:0] p;
    p = pcbc_pkg::PAT_NONE;
    if (m == pcbc_pkg::PCBC_BC_LEFT && !tsel) begin
      unique case (c)
        3'h5:    p = 6'h0C;
        3'h4:    p = 6'h0A;
        3'h6:    p = 6'h22;
        3'h2:    p = 6'h21;
        3'h3:    p = 6'h11;
        3'h1:    p = 6'h14;
        default: p = pcbc_pkg::PAT_NONE;
      endcase
    end else if (m == pcbc_pkg::PCBC_BC_LEFT) begin
      unique case (c)
        3'h5:    p = 6'h14;
        3'h4:    p = 6'h0C;
        3'h6:    p = 6'h0A;
        3'h2:    p = 6'h22;
        3'h3:    p = 6'h21;
        3'h1:    p = 6'h11;
        default: p = pcbc_pkg::PAT_NONE;
      endcase
    end else if (m == pcbc_pkg::PCBC_BC_RIGHT) begin
      unique case (c)
        3'h6:    p = 6'h11;
        3'h4:    p = 6'h21;
        3'h5:    p = 6'h22;
        3'h1:    p = 6'h0A;
        3'h3:    p = 6'h0C;
        3'h2:    p = 6'h14;
        default: p = pcbc_pkg::PAT_NONE;
      endcase
    end else if (m == pcbc_pkg::PCBC_BC_SLOW) begin
      p = pcbc_pkg::PAT_SLOW;
    end
    return p;
  endfunction

  // Legal successor of a Hall code in the selected rotation
  function automatic logic [2:0] pcbc_succ(
    input pcbc_pkg::pcbc_bc_e m,
    input logic [2:0]         c
  );
    logic [2:0] s;
    s = c;
    if (m == pcbc_pkg::PCBC_BC_LEFT) begin
      unique case (c)
        3'h5:    s = 3'h4;
        3'h4:    s = 3'h6;
        3'h6:    s = 3'h2;
        3'h2:    s = 3'h3;
        3'h3:    s = 3'h1;
        3'h1:    s = 3'h5;
        default: s = c;
      endcase
    end else begin
      unique case (c)
        3'h6:    s = 3'h4;
        3'h4:    s = 3'h5;
        3'h5:    s = 3'h1;
        3'h1:    s = 3'h3;
        3'h3:    s = 3'h2;
        3'h2:    s = 3'h6;
        default: s = c;
      endcase
    end
    return s;
  endfunction

  // Number of table steps of a multi-phase variant
  function automatic logic [2:0] pcbc_phases(input pcbc_pkg::pcbc_op_e op);
    logic [2:0] n;
    unique case (op)
      pcbc_pkg::PCBC_OP_MPWM4: n = 3'h4;
      pcbc_pkg::PCBC_OP_MPWM5: n = 3'h5;
      default:                 n = 3'h6;
    endcase
    return n;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic       rotating;
  logic       mpwm;
  logic       bad_code;
  logic       wrong_follow;
  logic       changed;
  logic       enter_idle;
  logic       mod_sig;
  logic [2:0] nph;

  always_comb begin
    next_st  = st;
    rotating = cfg.commutation_mode_sel == pcbc_pkg::PCBC_BC_LEFT ||
               cfg.commutation_mode_sel == pcbc_pkg::PCBC_BC_RIGHT;
    mpwm     = cfg.op_mode == pcbc_pkg::PCBC_OP_MPWM4 ||
               cfg.op_mode == pcbc_pkg::PCBC_OP_MPWM5 ||
               cfg.op_mode == pcbc_pkg::PCBC_OP_MPWM6;
    nph      = pcbc_phases(cfg.op_mode);

    // Period timer and single pin
    if (count_tick) begin
      if (st.count >= tmr.period_value) begin
        next_st.count = pcbc_pkg::TMR_RST;
      end else begin
        next_st.count = st.count + 10'h001;
      end
    end
    next_st.pwm = st.pwm ^ (count_tick && next_st.count == pcbc_pkg::TMR_RST)
                         ^ (count_tick && next_st.count == tmr.pwm_match_value);
    // Wrap toggle above, match toggle after it

    // Hall sampling and commutation
    next_st.hall_s = {hall_inputs[0], hall_inputs[1], hall_inputs[2]};
    changed      = cfg.op_mode == pcbc_pkg::PCBC_OP_BLOCK &&
                   (!st.last_valid || st.hall_s != st.hall_last);
    bad_code     = rotating && (st.hall_s == pcbc_pkg::HALL_LOW ||
                                st.hall_s == pcbc_pkg::HALL_HIGH);
    wrong_follow = rotating && cfg.follower_check_enable && st.last_valid &&
                   st.hall_s != st.hall_last &&
                   st.hall_s != pcbc_succ(cfg.commutation_mode_sel,
                                          st.hall_last);
    enter_idle   = changed && !st.idle && (bad_code || wrong_follow);

    if (error_clear) begin
      next_st.err = 1'b0;
    end
    if (enter_idle) begin
      next_st.err  = 1'b1;          // Set beats a same-cycle clear
      next_st.idle = 1'b1;
      next_st.pattern = pcbc_pkg::PAT_NONE;
    end else if (changed && (!st.idle || !st.err) && !bad_code) begin
      next_st.idle = 1'b0;
      next_st.pattern = pcbc_decode(cfg.commutation_mode_sel,
                                    cfg.phase_shift_sel, st.hall_s);
    end
    if (cfg.op_mode == pcbc_pkg::PCBC_OP_BLOCK && changed) begin
      next_st.hall_last  = st.hall_s;
      next_st.last_valid = !(error_clear && st.idle);
    end
    if (error_clear && st.idle) begin
      next_st.last_valid = 1'b0;    // Re-evaluate inputs once cleared
    end
    next_st.irq = next_st.err && cfg.emergency_int_enable;

    // Multi-phase stepping
    if (mpwm && (ct1_zero || sw_step)) begin
      if (st.step + pcbc_pkg::STEP_ONE >= nph) begin
        next_st.step = pcbc_pkg::STEP_RST;
      end else begin
        next_st.step = st.step + pcbc_pkg::STEP_ONE;
      end
      next_st.pattern = pcbc_pkg::PAT_FIRST << next_st.step;
    end else if (!mpwm && cfg.op_mode != pcbc_pkg::PCBC_OP_BLOCK) begin
      next_st.step    = pcbc_pkg::STEP_RST;
      next_st.pattern = pcbc_pkg::PAT_NONE;
    end

    // Output drive
    mod_sig = next_st.pwm ^ cfg.paired_invert_bit;
    if (cfg.op_mode == pcbc_pkg::PCBC_OP_BURST) begin
      next_st.prim = 3'h0;
      next_st.pair = {3{mod_sig}};
    end else if (cfg.op_mode == pcbc_pkg::PCBC_OP_COMPARE ||
                 (cfg.op_mode == pcbc_pkg::PCBC_OP_BLOCK &&
                  (next_st.idle ||
                   cfg.commutation_mode_sel == pcbc_pkg::PCBC_BC_IDLE))) begin
      next_st.prim = 3'h0;
      next_st.pair = 3'h0;
    end else begin
      next_st.prim = next_st.pattern[2:0];
      next_st.pair = next_st.pattern[5:3] &
                     (cfg.modulate_en ? {3{mod_sig}} : 3'h7);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.idle <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign single_pwm_pin         = st.pwm;
  assign primary_out            = st.prim;
  assign paired_out             = st.pair;
  assign commutation_error_flag = st.err;
  assign emergency_irq          = st.irq;

  // ****************************************
  // Checks
  // ****************************************
  property p_wrap;
    @(posedge mclk) disable iff (!rst_n)
      count_tick && st.count >= tmr.period_value |=> st.count == 10'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("timer did not wrap");

  property p_match;
    @(posedge mclk) disable iff (!rst_n)
      count_tick && st.count < tmr.period_value &&
      st.count + 10'h001 == tmr.pwm_match_value
      |=> single_pwm_pin != $past(single_pwm_pin);
  endproperty
  a_match: assert property (p_match) else $error("no match toggle");

  property p_zero;
    @(posedge mclk) disable iff (!rst_n)
      count_tick && st.count >= tmr.period_value &&
      tmr.pwm_match_value != 10'h000
      |=> single_pwm_pin != $past(single_pwm_pin);
  endproperty
  a_zero: assert property (p_zero) else $error("no wrap toggle");

  property p_burst;
    @(posedge mclk) disable iff (!rst_n)
      cfg.op_mode == pcbc_pkg::PCBC_OP_BURST ##1
      $stable(cfg.paired_invert_bit) && cfg.op_mode == pcbc_pkg::PCBC_OP_BURST
      |-> paired_out == {3{single_pwm_pin ^ cfg.paired_invert_bit}};
  endproperty
  a_burst: assert property (p_burst) else $error("burst drive bad");

  property p_step;
    @(posedge mclk) disable iff (!rst_n)
      cfg.op_mode == pcbc_pkg::PCBC_OP_MPWM6 && ct1_zero && st.step < 3'h5
      |=> st.step == $past(st.step) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("no table step");

  property p_bad;
    @(posedge mclk) disable iff (!rst_n)
      cfg.op_mode == pcbc_pkg::PCBC_OP_BLOCK && !st.idle &&
      cfg.commutation_mode_sel == pcbc_pkg::PCBC_BC_LEFT &&
      st.hall_s == 3'h0 && st.hall_last != 3'h0
      |=> commutation_error_flag && st.idle && primary_out == 3'h0;
  endproperty
  a_bad: assert property (p_bad) else $error("bad code not caught");

  property p_irq;
    @(posedge mclk) disable iff (!rst_n)
      commutation_error_flag && cfg.emergency_int_enable && !error_clear
      |=> emergency_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no emergency request");

  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
      commutation_error_flag && !error_clear |=> commutation_error_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped alone");

  property p_idle_out;
    @(posedge mclk) disable iff (!rst_n)
      cfg.op_mode == pcbc_pkg::PCBC_OP_BLOCK && $rose(st.idle)
      |-> commutation_error_flag && paired_out == 3'h0;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("idle w/o flag");

  property p_left;
    @(posedge mclk) disable iff (!rst_n)
      cfg.op_mode == pcbc_pkg::PCBC_OP_BLOCK && !st.idle && !st.err &&
      cfg.commutation_mode_sel == pcbc_pkg::PCBC_BC_LEFT &&
      !cfg.phase_shift_sel && !cfg.modulate_en && !cfg.follower_check_enable &&
      st.hall_s == 3'h5 && st.hall_last != 3'h5 ##1
      $stable(cfg) |-> primary_out == 3'h4 && paired_out == 3'h1;
  endproperty
  a_left: assert property (p_left) else $error("left map wrong");

endmodule
`default_nettype wire

/* File: shared/pcbc_pkg.sv */
// Package: constants, modes and carriers of the PWM/commutation block
`default_nettype none
package pcbc_pkg;

  // ****************************************
  // Widths, reset values and encodings
  // ****************************************
  localparam int unsigned TMR_W     = 10;
  localparam int unsigned CH_N      = 3;
  localparam logic [9:0]  TMR_RST   = 10'h000;
  localparam logic [2:0]  HALL_LOW  = 3'h0;
  localparam logic [2:0]  HALL_HIGH = 3'h7;
  localparam logic [5:0]  PAT_NONE  = 6'h00;
  localparam logic [5:0]  PAT_SLOW  = 6'h38;
  localparam logic [2:0]  STEP_RST  = 3'h0;
  localparam logic [2:0]  STEP_ONE  = 3'h1;
  localparam logic [5:0]  PAT_FIRST = 6'h01;
  localparam int unsigned INV_BIT   = 6;
  localparam int unsigned FCHK_BIT  = 7;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [2:0] {
    PCBC_OP_COMPARE,
    PCBC_OP_BLOCK,
    PCBC_OP_MPWM4,
    PCBC_OP_MPWM5,
    PCBC_OP_MPWM6,
    PCBC_OP_BURST
  } pcbc_op_e;

  typedef enum logic [1:0] {
    PCBC_BC_LEFT,
    PCBC_BC_RIGHT,
    PCBC_BC_SLOW,
    PCBC_BC_IDLE
  } pcbc_bc_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    pcbc_op_e   op_mode;
    pcbc_bc_e   commutation_mode_sel;
    logic       phase_shift_sel;
    logic       follower_check_enable;
    logic       paired_invert_bit;
    logic       modulate_en;
    logic       emergency_int_enable;
  } pcbc_cfg_s;

  typedef struct packed {
    logic [9:0] period_value;
    logic [9:0] pwm_match_value;
  } pcbc_tmr_s;

endpackage
`default_nettype wire

/* File: sim/pcbc_hall_model.sv */
// Hall sensor model: walks a rotor position along the commutation order
`default_nettype none
module pcbc_hall_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Control from the bench
  input  wire logic       load,
  input  wire logic [2:0] code,
  input  wire logic       step,
  input  wire logic       dir,
  input  wire logic       slow,
  // Sensor lines
  output logic [2:0]      hall
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pos;
  logic [2:0] lag0;
  logic [2:0] lag1;
  logic [2:0] lag2;
  logic [2:0] shown;
  // Next position, codes read as {in0,in1,in2}
  function automatic logic [2:0] succ(input logic [2:0] c, input logic d);
    case (c)
      3'h5: return d ? 3'h1 : 3'h4;
      3'h4: return d ? 3'h5 : 3'h6;
      3'h6: return d ? 3'h4 : 3'h2;
      3'h2: return d ? 3'h6 : 3'h3;
      3'h3: return d ? 3'h2 : 3'h1;
      3'h1: return d ? 3'h3 : 3'h5;
      default: return c;
    endcase
  endfunction
  // Slow sensors lag the rotor by three cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 3'h5;
      lag0 <= 3'h5;
      lag1 <= 3'h5;
      lag2 <= 3'h5;
    end else begin
      pos <= load ? code : (step ? succ(pos, dir) : pos);
      lag0 <= pos;
      lag1 <= lag0;
      lag2 <= lag1;
    end
  end
  assign shown = slow ? lag2 : pos;
  assign hall = {shown[0], shown[1], shown[2]};
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Testbench: timer, commutation, multi-phase and burst scenarios
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                mclk, rst_n, count_tick, ct1_zero, sw_step;
  logic                error_clear, ld, stp, dir, slw, pin, flag, irq;
  logic [2:0]          code, hall, pri, par;
  pcbc_pkg::pcbc_cfg_s cfg;
  pcbc_pkg::pcbc_tmr_s tmr;
  int                  error_cnt, compares;

  pcbc_top i_dut (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .tmr(tmr),
    .count_tick(count_tick), .hall_inputs(hall), .ct1_zero(ct1_zero),
    .sw_step(sw_step), .error_clear(error_clear), .single_pwm_pin(pin),
    .primary_out(pri), .paired_out(par), .commutation_error_flag(flag),
    .emergency_irq(irq));
  pcbc_hall_model i_hall (.mclk(mclk), .rst_n(rst_n), .load(ld),
    .code(code), .step(stp), .dir(dir), .slow(slw), .hall(hall));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk6(string nm, logic [5:0] e, logic [5:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    chk6(nm, {5'h00, e}, {5'h00, g});
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  // Reset, then mode {op, sel, tsel, fchk, inv, mod, irq_en}
  task automatic setup(pcbc_pkg::pcbc_op_e op, pcbc_pkg::pcbc_bc_e bc,
                       logic [4:0] f);
    @(posedge mclk);
    rst_n <= 1'b0;
    cyc(12);
    rst_n <= 1'b1;
    @(posedge mclk);
    cfg <= {op, bc, f};
  endtask
  task automatic hall_op(logic l, logic [2:0] c);
    @(posedge mclk);
    code <= c;
    ld <= l;
    stp <= !l;
    @(posedge mclk);
    ld <= 1'b0;
    stp <= 1'b0;
    cyc(6);
  endtask
  function automatic void adv(ref logic [9:0] c, ref logic p,
                              input logic [9:0] per, input logic [9:0] mt);
    c = (c >= per) ? 10'h000 : c + 10'h001;
    if (c == 10'h000) p = !p;
    if (c == mt) p = !p;
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_timer(logic [9:0] per, logic [9:0] mt, logic bst);
    logic [9:0] c;
    logic       p, tk;
    c = 10'h000;
    p = 1'b0;
    tk = 1'b0;
    setup(bst ? pcbc_pkg::PCBC_OP_BURST : pcbc_pkg::PCBC_OP_COMPARE,
          pcbc_pkg::PCBC_BC_LEFT, {2'b00, mt[9], 2'b10});
    tmr <= {per, mt};
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (tk) adv(c, p, per, mt);
      tk = bst || ((i % 5) != 3);
      count_tick <= tk;
      #1 chk1("pwm pin", p, pin);
      if (bst) chk6("burst", {{3{p ^ mt[9]}}, 3'h0}, {par, pri});
    end
    @(posedge mclk);
    count_tick <= 1'b0;
  endtask
  task automatic t_block(pcbc_pkg::pcbc_bc_e bc, logic ts, logic [35:0] e);
    logic r;
    r = bc == pcbc_pkg::PCBC_BC_RIGHT;
    setup(pcbc_pkg::PCBC_OP_BLOCK, bc, {ts, 4'h0});
    dir <= r;
    hall_op(1'b1, r ? 3'h6 : 3'h5);
    for (int i = 0; i < 7; i++) begin
      if (i > 0) hall_op(1'b0, 3'h0);
      chk6("phases", e[35 - 6 * (i % 6) -: 6], {par, pri});
    end
    chk1("error flag", 1'b0, flag);
  endtask
  task automatic t_error();
    setup(pcbc_pkg::PCBC_OP_BLOCK, pcbc_pkg::PCBC_BC_LEFT, 5'h01);
    slw <= 1'b1;
    hall_op(1'b1, 3'h0);
    chk6("phases", 6'h00, {par, pri});
    chk1("error flag", 1'b1, flag);
    chk1("emergency", 1'b1, irq);
    hall_op(1'b1, 3'h4);
    chk6("phases", 6'h00, {par, pri});
    @(posedge mclk);
    error_clear <= 1'b1;
    @(posedge mclk);
    error_clear <= 1'b0;
    cyc(3);
    chk6("phases", 6'h0A, {par, pri});
    chk1("error flag", 1'b0, flag);
    hall_op(1'b1, 3'h7);
    chk1("error flag", 1'b1, flag);
    slw <= 1'b0;
  endtask
  task automatic t_follow();
    setup(pcbc_pkg::PCBC_OP_BLOCK, pcbc_pkg::PCBC_BC_LEFT, 5'h08);
    dir <= 1'b0;
    hall_op(1'b0, 3'h0);
    chk6("phases", 6'h0A, {par, pri});
    hall_op(1'b1, 3'h2);
    chk6("phases", 6'h00, {par, pri});
    chk1("error flag", 1'b1, flag);
    chk1("emergency", 1'b0, irq);
  endtask
  task automatic t_fixed(pcbc_pkg::pcbc_bc_e bc, logic [5:0] e);
    setup(pcbc_pkg::PCBC_OP_BLOCK, bc, 5'h00);
    hall_op(1'b1, 3'h4);
    chk6("fixed rows", e, {par, pri});
  endtask
  task automatic t_mpwm();
    for (int n = 4; n <= 6; n++) begin
      setup(pcbc_pkg::pcbc_op_e'(3'(n - 2)), pcbc_pkg::PCBC_BC_LEFT, 5'h00);
      for (int k = 1; k <= n + 1; k++) begin
        @(posedge mclk);
        ct1_zero <= k[0];
        sw_step <= !k[0];
        @(posedge mclk);
        ct1_zero <= 1'b0;
        sw_step <= 1'b0;
        cyc(2);
        chk6("phase step", 6'h01 << (k % n), {par, pri});
      end
    end
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic stop_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    cyc(20000);
    error_cnt++;
    $display("unexpected timeout: expected end seen hang");
    stop_test();
  end
  initial begin
    {rst_n, count_tick, ct1_zero, sw_step, error_clear} = 5'h00;
    {ld, stp, dir, slw, code} = 7'h00;
    cfg = '0;
    tmr = '0;
    error_cnt = 0;
    compares = 0;
    setup(pcbc_pkg::PCBC_OP_COMPARE, pcbc_pkg::PCBC_BC_LEFT, 5'h00);
    #1 chk6("reset", 6'h00, {par, pri});
    chk1("reset flag", 1'b0, flag);
    chk1("reset pin", 1'b0, pin);
    $display("test reset done");
    t_timer(10'h005, 10'h002, 1'b0);
    t_timer(10'h003, 10'h000, 1'b0);
    t_timer(10'h002, 10'h1FF, 1'b0);
    t_timer(10'h003, 10'h001, 1'b1);
    t_timer(10'h003, 10'h201, 1'b1);
    $display("test timer and burst done");
    t_block(pcbc_pkg::PCBC_BC_LEFT, 1'b0, 36'h30A8A1454);
    t_block(pcbc_pkg::PCBC_BC_LEFT, 1'b1, 36'h50C2A2851);
    t_block(pcbc_pkg::PCBC_BC_RIGHT, 1'b0, 36'h46188A314);
    $display("test commutation tables done");
    t_error();
    t_follow();
    $display("test error handling done");
    t_fixed(pcbc_pkg::PCBC_BC_SLOW, 6'h38);
    t_fixed(pcbc_pkg::PCBC_BC_IDLE, 6'h00);
    t_mpwm();
    $display("test fixed rows and multi-phase done");
    stop_test();
  end
endmodule
`default_nettype wire
